// [hdl/dxu_data_move_unit.sv]
// Data move and exchange unit: register file, flags, APB slave, memory port
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "dxu_regs.svh"
module dxu_data_move_unit (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   mem_req,
  output dxu_pkg::dxu_mreq_t     mem_info,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_ack,
  output logic                   mem_lock
);
  logic [31:0]          gpr_ff [8];
  logic [31:0]          flags_ff, addr_ff, imm_ff, tmp_ff, tmp_hi_ff, sp_base_ff;
  dxu_pkg::dxu_cmd_t    cmd_ff;
  dxu_pkg::dxu_state_t  state_ff;
  logic [2:0]           step_ff;
  logic                 lock_ff;
  logic                 hit_ff;
  logic [31:0]          src_val, dst_val, acc, sp, adj, opnd, rd_val;
  logic [32:0]          sum, diff;
  logic                 hit, eq, eq64, mem_op, locked_op, idle, acc_phase;
  logic                 mapped, ack_go;
  logic [2:0]           last_step, pop_idx;
  dxu_pkg::dxu_mreq_t   req;

  // ----------------------------------------
  // Flag builder for add (sub=0) and a-b (sub=1)
  // ----------------------------------------
  function automatic logic [31:0] arith_flags(input logic [31:0] old, input logic [31:0] a,
                                              input logic [31:0] b, input logic [32:0] r,
                                              input logic sub);
    logic [31:0] f;
    f = old;
    f[`DXU_CARRY_BIT]  = r[32];
    f[`DXU_PARITY_BIT] = ~^r[7:0];
    f[`DXU_ZERO_BIT]   = (r[31:0] == 32'h0000_0000);
    f[`DXU_SIGN_BIT]   = r[31];
    f[`DXU_OVF_BIT]    = ((a[31] ^ b[31]) == sub) && (r[31] != a[31]);
    return f;
  endfunction

  // Keeps the upper half for 16-bit loads
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic w16);
    return w16 ? {old[31:16], nw[15:0]} : nw;
  endfunction

  // ----------------------------------------
  // Operand views and datapath
  // ----------------------------------------
  assign idle    = (state_ff == dxu_pkg::ST_IDLE);
  assign src_val = gpr_ff[cmd_ff.src];
  assign dst_val = gpr_ff[cmd_ff.dst];
  assign acc     = gpr_ff[`DXU_ACC_IDX];
  assign sp      = gpr_ff[`DXU_SP_IDX];
  assign adj     = cmd_ff.w16 ? `DXU_ADJ16 : `DXU_ADJ32;
  assign opnd    = cmd_ff.mem ? tmp_ff : dst_val;
  assign sum     = {1'b0, opnd} + {1'b0, src_val};
  assign diff    = {1'b0, acc} - {1'b0, opnd};
  assign eq      = (acc == opnd);
  assign eq64    = ({gpr_ff[`DXU_DHI_IDX], acc} == {tmp_hi_ff, tmp_ff});
  assign pop_idx = ~step_ff;
  assign ack_go  = (state_ff == dxu_pkg::ST_MEM) && mem_ack;
  assign rd_val  = merge(dst_val, cmd_ff.mem ? mem_rdata : src_val, cmd_ff.w16);

  dxu_cond_eval u_cond (
    .cc    (cmd_ff.cc),
    .flags (flags_ff),
    .hit   (hit)
  );

  // Which ops touch memory, how many accesses, which lock the bus
  always_comb begin
    unique case (cmd_ff.op)
      dxu_pkg::OP_SWAP, dxu_pkg::OP_SUM, dxu_pkg::OP_CSWAP: begin
        mem_op    = cmd_ff.mem;
        last_step = 3'h1;
      end
      dxu_pkg::OP_CMOV: begin
        mem_op    = cmd_ff.mem;
        last_step = 3'h0;
      end
      dxu_pkg::OP_CSWAP64: begin
        mem_op    = 1'b1;
        last_step = 3'h3;
      end
      dxu_pkg::OP_PUSH, dxu_pkg::OP_POP: begin
        mem_op    = 1'b1;
        last_step = 3'h0;
      end
      dxu_pkg::OP_PUSH_ALL, dxu_pkg::OP_POP_ALL: begin
        mem_op    = 1'b1;
        last_step = 3'h7;
      end
      default: begin
        mem_op    = 1'b0;
        last_step = 3'h0;
      end
    endcase
    // Swap with memory always locks; others only with the prefix
    locked_op = (cmd_ff.op == dxu_pkg::OP_SWAP && cmd_ff.mem) ||
                (cmd_ff.lock && cmd_ff.mem && (cmd_ff.op == dxu_pkg::OP_SUM ||
                 cmd_ff.op == dxu_pkg::OP_CSWAP)) ||
                (cmd_ff.lock && cmd_ff.op == dxu_pkg::OP_CSWAP64);
  end

  // ----------------------------------------
  // Memory request of the current step
  // ----------------------------------------
  always_comb begin
    req.we    = 1'b0;
    req.half  = cmd_ff.w16;
    req.addr  = addr_ff;
    req.wdata = src_val;
    unique case (cmd_ff.op)
      dxu_pkg::OP_SWAP:  req.we = step_ff[0];
      dxu_pkg::OP_SUM: begin
        req.we    = step_ff[0];
        req.wdata = sum[31:0];
      end
      dxu_pkg::OP_CSWAP: begin
        // Unequal case writes the old value back so the lock pairs up
        req.we    = step_ff[0];
        req.wdata = eq ? src_val : tmp_ff;
      end
      dxu_pkg::OP_CSWAP64: begin
        req.we    = step_ff[1];
        req.half  = 1'b0;
        req.addr  = step_ff[0] ? addr_ff + `DXU_HI_OFS : addr_ff;
        if (step_ff[0]) begin
          req.wdata = eq64 ? gpr_ff[`DXU_CNT_IDX] : tmp_hi_ff;
        end else begin
          req.wdata = eq64 ? gpr_ff[`DXU_BASE_IDX] : tmp_ff;
        end
      end
      dxu_pkg::OP_PUSH: begin
        req.we    = 1'b1;
        req.addr  = sp - adj;
        req.wdata = cmd_ff.imm_src ? imm_ff : src_val;
      end
      dxu_pkg::OP_PUSH_ALL: begin
        req.we    = 1'b1;
        req.addr  = sp - adj;
        req.wdata = (step_ff == `DXU_SP_IDX) ? sp_base_ff : gpr_ff[step_ff];
      end
      dxu_pkg::OP_POP, dxu_pkg::OP_POP_ALL: req.addr = sp;
      default: req.we = 1'b0;
    endcase
  end

  assign mem_req  = (state_ff == dxu_pkg::ST_MEM);
  assign mem_info = req;
  assign mem_lock = lock_ff;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= dxu_pkg::ST_IDLE;
      step_ff  <= 3'h0;
    end else begin
      unique case (state_ff)
        dxu_pkg::ST_IDLE: begin
          step_ff <= 3'h0;
          if (psel && penable && pwrite && paddr == `DXU_CMD_OFS) begin
            state_ff <= dxu_pkg::ST_EXEC;
          end
        end
        dxu_pkg::ST_EXEC: state_ff <= mem_op ? dxu_pkg::ST_MEM : dxu_pkg::ST_IDLE;
        dxu_pkg::ST_MEM: begin
          if (mem_ack && step_ff == last_step) begin
            state_ff <= dxu_pkg::ST_IDLE;
          end else if (mem_ack) begin
            step_ff <= step_ff + 3'h1;
          end
        end
        default: state_ff <= dxu_pkg::ST_IDLE;
      endcase
    end
  end

  // Bus lock spans every step of a locked sequence, reads and writes alike
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= 1'b0;
    end else if (state_ff == dxu_pkg::ST_EXEC) begin
      lock_ff <= mem_op && locked_op;
    end else if (ack_go && step_ff == last_step) begin
      lock_ff <= 1'b0;
    end
  end

  // Read data capture and saved pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmp_ff     <= `DXU_RST_WORD;
      tmp_hi_ff  <= `DXU_RST_WORD;
      sp_base_ff <= `DXU_RST_WORD;
      hit_ff     <= 1'b0;
    end else begin
      if (state_ff == dxu_pkg::ST_EXEC) begin
        sp_base_ff <= sp;
        hit_ff     <= hit;
      end
      if (ack_go && !req.we && step_ff == 3'h0) begin
        tmp_ff <= mem_rdata;
      end
      if (ack_go && !req.we && step_ff == 3'h1) begin
        tmp_hi_ff <= mem_rdata;
      end
    end
  end

  // ----------------------------------------
  // APB slave: zero wait states, error on unmapped word
  // ----------------------------------------
  assign acc_phase = psel && penable;
  assign mapped    = (paddr[1:0] == 2'b00) && (paddr <= `DXU_STAT_OFS);
  assign pready    = 1'b1;
  assign pslverr   = acc_phase && !mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr < `DXU_FLAGS_OFS) begin
      prdata = gpr_ff[paddr[4:2]];
    end else if (paddr == `DXU_FLAGS_OFS) begin
      prdata = flags_ff;
    end else if (paddr == `DXU_CMD_OFS) begin
      prdata = {14'h0000, cmd_ff};
    end else if (paddr == `DXU_ADDR_OFS) begin
      prdata = addr_ff;
    end else if (paddr == `DXU_IMM_OFS) begin
      prdata = imm_ff;
    end else if (paddr == `DXU_STAT_OFS) begin
      prdata[`DXU_BUSY_BIT] = !idle;
      prdata[`DXU_LOCK_BIT] = lock_ff;
      prdata[`DXU_HIT_BIT]  = hit_ff;
    end
  end

  // Command and operand registers; writes while busy are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff  <= '0;
      addr_ff <= `DXU_RST_WORD;
      imm_ff  <= `DXU_RST_WORD;
    end else if (acc_phase && pwrite && idle) begin
      if (paddr == `DXU_CMD_OFS) begin
        cmd_ff <= dxu_pkg::dxu_cmd_t'(pwdata[`DXU_CMD_W-1:0]);
      end
      if (paddr == `DXU_ADDR_OFS) begin
        addr_ff <= pwdata;
      end
      if (paddr == `DXU_IMM_OFS) begin
        imm_ff <= pwdata;
      end
    end
  end

  // ----------------------------------------
  // Flags register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= `DXU_RST_WORD;
    end else if (acc_phase && pwrite && idle && paddr == `DXU_FLAGS_OFS) begin
      flags_ff <= pwdata;
    end else if ((state_ff == dxu_pkg::ST_EXEC && !mem_op) || (ack_go && req.we)) begin
      if (cmd_ff.op == dxu_pkg::OP_SUM) begin
        flags_ff <= arith_flags(flags_ff, opnd, src_val, sum, 1'b0);
      end else if (cmd_ff.op == dxu_pkg::OP_CSWAP) begin
        flags_ff <= arith_flags(flags_ff, acc, opnd, diff, 1'b1);
      end else if (cmd_ff.op == dxu_pkg::OP_CSWAP64 && step_ff == 3'h3) begin
        flags_ff[`DXU_ZERO_BIT] <= eq64;
      end
    end
  end

  // ----------------------------------------
  // General register file
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        gpr_ff[i] <= `DXU_RST_WORD;
      end
    end else if (acc_phase && pwrite && idle && paddr < `DXU_FLAGS_OFS) begin
      gpr_ff[paddr[4:2]] <= pwdata;
    end else if (state_ff == dxu_pkg::ST_EXEC && !mem_op) begin
      unique case (cmd_ff.op)
        dxu_pkg::OP_SWAP: begin
          gpr_ff[cmd_ff.src] <= dst_val;
          gpr_ff[cmd_ff.dst] <= src_val;
        end
        dxu_pkg::OP_BREV: gpr_ff[cmd_ff.dst] <= {dst_val[7:0], dst_val[15:8],
                                                 dst_val[23:16], dst_val[31:24]};
        dxu_pkg::OP_SUM: begin
          gpr_ff[cmd_ff.src] <= dst_val;
          gpr_ff[cmd_ff.dst] <= sum[31:0];
        end
        dxu_pkg::OP_CSWAP: begin
          if (eq) begin
            gpr_ff[cmd_ff.dst] <= src_val;
          end else begin
            gpr_ff[`DXU_ACC_IDX] <= dst_val;
          end
        end
        dxu_pkg::OP_CMOV: begin
          if (hit) begin
            gpr_ff[cmd_ff.dst] <= rd_val;
          end
        end
        dxu_pkg::OP_B2W:    gpr_ff[`DXU_ACC_IDX][15:8] <= {8{acc[7]}};
        dxu_pkg::OP_W2D:    gpr_ff[`DXU_ACC_IDX][31:16] <= {16{acc[15]}};
        dxu_pkg::OP_W2PAIR: gpr_ff[`DXU_DHI_IDX][15:0] <= {16{acc[15]}};
        dxu_pkg::OP_D2PAIR: gpr_ff[`DXU_DHI_IDX] <= {32{acc[31]}};
        default: gpr_ff[`DXU_ACC_IDX] <= acc;
      endcase
    end else if (ack_go) begin
      unique case (cmd_ff.op)
        dxu_pkg::OP_SWAP, dxu_pkg::OP_SUM: begin
          // Register takes the old word only at the write, so the write still sees src
          if (req.we) begin
            gpr_ff[cmd_ff.src] <= tmp_ff;
          end
        end
        dxu_pkg::OP_CSWAP: begin
          if (req.we && !eq) begin
            gpr_ff[`DXU_ACC_IDX] <= tmp_ff;
          end
        end
        dxu_pkg::OP_CSWAP64: begin
          if (step_ff == 3'h3 && !eq64) begin
            gpr_ff[`DXU_ACC_IDX] <= tmp_ff;
            gpr_ff[`DXU_DHI_IDX] <= tmp_hi_ff;
          end
        end
        dxu_pkg::OP_CMOV: begin
          if (hit) begin
            gpr_ff[cmd_ff.dst] <= rd_val;
          end
        end
        dxu_pkg::OP_PUSH, dxu_pkg::OP_PUSH_ALL: gpr_ff[`DXU_SP_IDX] <= req.addr;
        dxu_pkg::OP_POP: begin
          gpr_ff[`DXU_SP_IDX] <= sp + adj;
          gpr_ff[cmd_ff.dst]  <= merge(dst_val, mem_rdata, cmd_ff.w16);
        end
        dxu_pkg::OP_POP_ALL: begin
          gpr_ff[`DXU_SP_IDX] <= sp + adj;
          if (pop_idx != `DXU_SP_IDX) begin
            gpr_ff[pop_idx] <= merge(gpr_ff[pop_idx], mem_rdata, cmd_ff.w16);
          end
        end
        default: gpr_ff[`DXU_ACC_IDX] <= acc;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic ex_reg;
  assign ex_reg = (state_ff == dxu_pkg::ST_EXEC) && !mem_op;

  AST_BREV: assert property (ex_reg && cmd_ff.op == dxu_pkg::OP_BREV |=>
    gpr_ff[cmd_ff.dst][7:0] == $past(dst_val[31:24]) &&
    gpr_ff[cmd_ff.dst][15:8] == $past(dst_val[23:16])) else $error("byte reverse wrong");
  AST_B2W: assert property (ex_reg && cmd_ff.op == dxu_pkg::OP_B2W |=>
    acc[15:8] == {8{$past(acc[7])}}) else $error("byte to word wrong");
  AST_W2D: assert property (ex_reg && cmd_ff.op == dxu_pkg::OP_W2D |=>
    acc[31:16] == {16{$past(acc[15])}}) else $error("word to dword wrong");
  AST_D2PAIR: assert property (ex_reg && cmd_ff.op == dxu_pkg::OP_D2PAIR |=>
    gpr_ff[`DXU_DHI_IDX] == {32{$past(acc[31])}}) else $error("dword to pair wrong");
  AST_CMOV_MISS: assert property (ex_reg && cmd_ff.op == dxu_pkg::OP_CMOV && !hit |=>
    $stable(dst_val)) else $error("false condition moved data");
  AST_SWAP_LOCK: assert property (mem_req && cmd_ff.op == dxu_pkg::OP_SWAP |->
    mem_lock) else $error("memory swap without bus lock");
  AST_PUSH_ADDR: assert property (mem_req && cmd_ff.op == dxu_pkg::OP_PUSH |->
    req.we && req.addr == sp - adj) else $error("push address wrong");
  AST_POP_STEP: assert property (ack_go && cmd_ff.op == dxu_pkg::OP_POP &&
    cmd_ff.dst != `DXU_SP_IDX |=> sp == $past(sp) + $past(adj)) else $error("pop step wrong");
  AST_CSWAP_NE: assert property (ex_reg && cmd_ff.op == dxu_pkg::OP_CSWAP && !eq |=>
    acc == $past(dst_val) && $stable(dst_val)) else $error("compare swap miss wrong");
  AST_REG_DONE: assert property (ex_reg |=> idle) else $error("register op not done");

  COV_PUSH_ALL: cover property (ack_go && cmd_ff.op == dxu_pkg::OP_PUSH_ALL && step_ff == 3'h7);
  COV_CS64_EQ: cover property (ack_go && cmd_ff.op == dxu_pkg::OP_CSWAP64 && eq64);
  COV_SWAP_MEM: cover property (ack_go && cmd_ff.op == dxu_pkg::OP_SWAP && req.we);
endmodule

// [hdl/dxu_regs.svh]
// Register offsets, field positions, reset values and stack steps of the data move unit
`ifndef DXU_REGS_SVH
`define DXU_REGS_SVH

// ----------------------------------------
// Byte offsets (general register i at 4*i)
// ----------------------------------------
`define DXU_GPR_OFS    8'h00
`define DXU_FLAGS_OFS  8'h20
`define DXU_CMD_OFS    8'h24
`define DXU_ADDR_OFS   8'h28
`define DXU_IMM_OFS    8'h2C
`define DXU_STAT_OFS   8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DXU_CARRY_BIT  0
`define DXU_PARITY_BIT 2
`define DXU_ZERO_BIT   6
`define DXU_SIGN_BIT   7
`define DXU_OVF_BIT    11
`define DXU_BUSY_BIT   0
`define DXU_LOCK_BIT   1
`define DXU_HIT_BIT    2
`define DXU_CMD_W      18

// ----------------------------------------
// Register indices, reset value, stack steps
// ----------------------------------------
`define DXU_ACC_IDX    3'h0
`define DXU_CNT_IDX    3'h1
`define DXU_DHI_IDX    3'h2
`define DXU_BASE_IDX   3'h3
`define DXU_SP_IDX     3'h4
`define DXU_RST_WORD   32'h0000_0000
`define DXU_ADJ32      32'h0000_0004
`define DXU_ADJ16      32'h0000_0002
`define DXU_HI_OFS     32'h0000_0004

`endif

// [hdl/dxu_pkg.sv]
// Types shared by the data move unit files
package dxu_pkg;

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_SWAP     = 4'b0000,
    OP_BREV     = 4'b0001,
    OP_SUM      = 4'b0010,
    OP_CSWAP    = 4'b0011,
    OP_CSWAP64  = 4'b0100,
    OP_CMOV     = 4'b0101,
    OP_PUSH     = 4'b0110,
    OP_POP      = 4'b0111,
    OP_PUSH_ALL = 4'b1000,
    OP_POP_ALL  = 4'b1001,
    OP_B2W      = 4'b1010,
    OP_W2D      = 4'b1011,
    OP_W2PAIR   = 4'b1100,
    OP_D2PAIR   = 4'b1101,
    OP_RSV_E    = 4'b1110,
    OP_RSV_F    = 4'b1111
  } dxu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_MEM  = 2'b10
  } dxu_state_t;

  // Command word, low bits first: op, cond, dst, src, mem, lock, w16, imm
  typedef struct packed {
    logic       imm_src;
    logic       w16;
    logic       lock;
    logic       mem;
    logic [2:0] src;
    logic [2:0] dst;
    logic [3:0] cc;
    dxu_op_t    op;
  } dxu_cmd_t;

  // Memory request
  typedef struct packed {
    logic        we;
    logic        half;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dxu_mreq_t;

endpackage

// [hdl/dxu_cond_eval.sv]
// Condition code evaluator for the conditional move
`timescale 1ns/10ps
`include "dxu_regs.svh"
module dxu_cond_eval (
  input  wire logic [3:0]  cc,
  input  wire logic [31:0] flags,
  output logic             hit
);
  logic cf, pf, zf, sf, of, base;

  // ----------------------------------------
  // Base test, odd codes invert it
  // ----------------------------------------
  always_comb begin
    cf = flags[`DXU_CARRY_BIT];
    pf = flags[`DXU_PARITY_BIT];
    zf = flags[`DXU_ZERO_BIT];
    sf = flags[`DXU_SIGN_BIT];
    of = flags[`DXU_OVF_BIT];
    unique case (cc[3:1])
      3'h0: base = of;
      3'h1: base = cf;
      3'h2: base = zf;
      3'h3: base = cf | zf;
      3'h4: base = sf;
      3'h5: base = pf;
      3'h6: base = sf ^ of;
      3'h7: base = (sf ^ of) | zf;
    endcase
    hit = base ^ cc[0];
  end
endmodule

// [tb/dxu_mem_model.sv]
// Memory partner model for the data move unit bench
`timescale 1ns/10ps
module dxu_mem_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               slow,
  input  wire logic               mem_req,
  input  wire dxu_pkg::dxu_mreq_t mem_info,
  output logic [31:0]             mem_rdata,
  output logic                    mem_ack
);
  // ----------------------------------------
  // Word store and acknowledge timing
  // ----------------------------------------
  logic [31:0] mem [0:255];
  logic [1:0]  wait_ff;
  wire  [7:0]  idx = mem_info.addr[9:2];

  // Data only valid with ack; inverted otherwise so stale reads show
  assign mem_rdata = mem_ack ? mem[idx] : ~mem[idx];

  // Ack after one or three waits, never two accesses per ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_ff <= 2'h0;
    end else begin
      mem_ack <= mem_req && !mem_ack && (wait_ff >= (slow ? 2'h2 : 2'h0));
      wait_ff <= (mem_req && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
    end
  end

  // Stores land at the ack edge; half size keeps the upper half
  always @(posedge clk) begin
    if (mem_req && mem_ack && mem_info.we) begin
      mem[idx][15:0] <= mem_info.wdata[15:0];
      if (!mem_info.half) mem[idx][31:16] <= mem_info.wdata[31:16];
    end
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the data move unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  // ----------------------------------------
  // Signals, instances, clock
  // ----------------------------------------
  logic               clk, rst_n, psel, penable, pwrite, slow, err_seen;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, mem_rdata, rdv;
  logic               pready, pslverr, mem_req, mem_ack, mem_lock;
  dxu_pkg::dxu_mreq_t mem_info;
  int                 n_fail, check_count, rq_cnt, lk_cnt, i;

  dxu_data_move_unit DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_info(mem_info), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .mem_lock(mem_lock));
  dxu_mem_model mm (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_req(mem_req),
    .mem_info(mem_info), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Lock coverage of every memory cycle
  always @(posedge clk) begin
    if (mem_req === 1'b1) rq_cnt++;
    if (mem_req === 1'b1 && mem_lock === 1'b1) lk_cnt++;
  end

  // ----------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer settles before the edge; values taken here are those seen at it
    for (k = 0; k < 9; k++) begin
      @(negedge clk);
      rdy = pready;
      rdv = prdata;
      err_seen = pslverr;
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    if (k == 9) begin
      n_fail++;
      test_done;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task ck(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(n, e, rdv);
  endtask

  // Command word: fl = {imm, w16, lock, mem}; waits out busy, bounded
  task ex(input logic [3:0] op, cc, input logic [2:0] d, s, input logic [3:0] fl);
    int k;
    apb(1'b1, 8'h24, {14'h0000, fl, s, d, cc, op});
    for (k = 0; k < 40; k++) begin
      apb(1'b0, 8'h30, 32'h0000_0000);
      if (rdv[0] === 1'b0) break;
    end
    if (k == 40) begin
      n_fail++;
      test_done;
    end
  endtask

  function automatic logic ch(input logic [3:0] cc, input logic [31:0] f);
    logic r;
    case (cc[3:1])
      3'h0: r = f[11];
      3'h1: r = f[0];
      3'h2: r = f[6];
      3'h3: r = f[0] | f[6];
      3'h4: r = f[7];
      3'h5: r = f[2];
      3'h6: r = f[7] ^ f[11];
      default: r = (f[7] ^ f[11]) | f[6];
    endcase
    return r ^ cc[0];
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_swap;
    apb(1'b1, 8'h04, 32'h1111_2222);
    apb(1'b1, 8'h0C, 32'hAAAA_5555);
    ex(dxu_pkg::OP_SWAP, 4'h0, 3'h1, 3'h3, 4'h0);
    ck(8'h04, 32'hAAAA_5555, "swap dst");
    ck(8'h0C, 32'h1111_2222, "swap src");
    slow <= 1'b1;
    mm.mem[16] = 32'h0BAD_F00D;
    apb(1'b1, 8'h28, 32'h0000_0040);
    rq_cnt = 0;
    lk_cnt = 0;
    ex(dxu_pkg::OP_SWAP, 4'h0, 3'h1, 3'h1, 4'h1);
    ck(8'h04, 32'h0BAD_F00D, "mswap reg");
    `CHK("mswap mem", 32'hAAAA_5555, mm.mem[16]);
    `CHK("mswap lock", rq_cnt, lk_cnt);
    `CHK("mswap reqs", 1'b1, rq_cnt > 1);
    apb(1'b1, 8'h1C, 32'h1234_5678);
    ex(dxu_pkg::OP_BREV, 4'h0, 3'h7, 3'h0, 4'h0);
    ck(8'h1C, 32'h7856_3412, "brev");
    $display("swap test end");
  endtask

  task t_cmov;
    logic [31:0] fv [4] = '{32'h0000_0000, 32'h0000_0041, 32'h0000_0080, 32'h0000_0804};
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 16; c++) begin
        apb(1'b1, 8'h20, fv[f]);
        apb(1'b1, 8'h04, 32'h1111_1111);
        apb(1'b1, 8'h0C, 32'h2222_2222);
        ex(dxu_pkg::OP_CMOV, 4'(c), 3'h1, 3'h3, 4'h0);
        `CHK("cmov hit", ch(4'(c), fv[f]), rdv[2]);
        ck(8'h04, ch(4'(c), fv[f]) ? 32'h2222_2222 : 32'h1111_1111, "cmov");
      end
    end
    $display("cmov test end");
  endtask

  task t_arith;
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    ex(dxu_pkg::OP_SUM, 4'h0, 3'h1, 3'h3, 4'h0);
    ck(8'h04, 32'h0000_0000, "sum dst");
    ck(8'h0C, 32'hFFFF_FFFF, "sum src");
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("sum zf cf", 2'b11, {rdv[6], rdv[0]});
    apb(1'b1, 8'h00, 32'h0000_0005);
    apb(1'b1, 8'h04, 32'h0000_0005);
    apb(1'b1, 8'h0C, 32'h0000_0009);
    ex(dxu_pkg::OP_CSWAP, 4'h0, 3'h1, 3'h3, 4'h0);
    ck(8'h04, 32'h0000_0009, "cs eq dst");
    apb(1'b1, 8'h00, 32'h0000_0003);
    ex(dxu_pkg::OP_CSWAP, 4'h0, 3'h1, 3'h3, 4'h0);
    ck(8'h00, 32'h0000_0009, "cs ne acc");
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("cs flags", 3'b101, {rdv[7], rdv[6], rdv[0]});
    $display("arith test end");
  endtask

  task t_c64;
    apb(1'b1, 8'h00, 32'hA000_0000);
    apb(1'b1, 8'h08, 32'hD000_0000);
    apb(1'b1, 8'h0C, 32'hB000_0000);
    apb(1'b1, 8'h04, 32'hC000_0000);
    mm.mem[32] = 32'hA000_0000;
    mm.mem[33] = 32'hD000_0000;
    apb(1'b1, 8'h28, 32'h0000_0080);
    rq_cnt = 0;
    lk_cnt = 0;
    ex(dxu_pkg::OP_CSWAP64, 4'h0, 3'h0, 3'h0, 4'h3);
    `CHK("c64 lo", 32'hB000_0000, mm.mem[32]);
    `CHK("c64 hi", 32'hC000_0000, mm.mem[33]);
    `CHK("c64 lock", rq_cnt, lk_cnt);
    ex(dxu_pkg::OP_CSWAP64, 4'h0, 3'h0, 3'h0, 4'h3);
    ck(8'h00, 32'hB000_0000, "c64 acc");
    ck(8'h08, 32'hC000_0000, "c64 dhi");
    $display("c64 test end");
  endtask

  task t_stack;
    slow <= 1'b0;
    apb(1'b1, 8'h10, 32'h0000_0100);
    apb(1'b1, 8'h04, 32'hCAFE_0001);
    ex(dxu_pkg::OP_PUSH, 4'h0, 3'h1, 3'h1, 4'h0);
    `CHK("push mem", 32'hCAFE_0001, mm.mem[63]);
    ck(8'h10, 32'h0000_00FC, "push sp");
    ex(dxu_pkg::OP_POP, 4'h0, 3'h2, 3'h2, 4'h0);
    ck(8'h08, 32'hCAFE_0001, "pop dst");
    ck(8'h10, 32'h0000_0100, "pop sp");
    ex(dxu_pkg::OP_PUSH, 4'h0, 3'h1, 3'h1, 4'h4);
    ck(8'h10, 32'h0000_00FE, "push16 sp");
    for (i = 0; i < 8; i++) apb(1'b1, 8'(4 * i), i == 4 ? 32'h0000_0200 : 32'h1000_0000 + i);
    ex(dxu_pkg::OP_PUSH_ALL, 4'h0, 3'h0, 3'h0, 4'h0);
    for (i = 0; i < 8; i++) begin
      `CHK("push_all_op", i == 4 ? 32'h0000_0200 : 32'h1000_0000 + i, mm.mem[127 - i]);
      if (i != 4) apb(1'b1, 8'(4 * i), 32'h0000_0000);
    end
    ck(8'h10, 32'h0000_01E0, "push_all_op sp");
    ex(dxu_pkg::OP_POP_ALL, 4'h0, 3'h0, 3'h0, 4'h0);
    for (i = 0; i < 8; i++) begin
      if (i != 4) ck(8'(4 * i), 32'h1000_0000 + i, "pop_all_op");
    end
    ck(8'h10, 32'h0000_0200, "pop_all_op sp");
    $display("stack test end");
  endtask

  task t_conv;
    apb(1'b1, 8'h00, 32'h1234_5680);
    ex(dxu_pkg::OP_B2W, 4'h0, 3'h0, 3'h0, 4'h0);
    ck(8'h00, 32'h1234_FF80, "b2w");
    apb(1'b1, 8'h00, 32'h0000_8001);
    ex(dxu_pkg::OP_W2D, 4'h0, 3'h0, 3'h0, 4'h0);
    ck(8'h00, 32'hFFFF_8001, "w2d");
    apb(1'b1, 8'h08, 32'h1234_0000);
    ex(dxu_pkg::OP_W2PAIR, 4'h0, 3'h0, 3'h0, 4'h0);
    ck(8'h08, 32'h1234_FFFF, "w2pair");
    apb(1'b1, 8'h00, 32'h7FFF_FFFF);
    ex(dxu_pkg::OP_D2PAIR, 4'h0, 3'h0, 3'h0, 4'h0);
    ck(8'h08, 32'h0000_0000, "d2pair");
    $display("conv test end");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, slow, paddr, pwdata} = '0;
    for (i = 0; i < 256; i++) mm.mem[i] = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    ck(8'h20, 32'h0000_0000, "flags rst");
    apb(1'b0, 8'h34, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err_seen);
    t_swap;
    t_cmov;
    t_arith;
    t_c64;
    t_stack;
    t_conv;
    test_done;
  end
endmodule
